//--- rtl/diag_record_pkg.sv
// constants and types for the analog input diagnostic record
package diag_record_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int TICK_PERIOD_PS = 1000000;
	localparam int CYC_PER_US = TICK_PERIOD_PS / CLK_PERIOD_PS;
	localparam logic [7:0] PRE_LAST = 8'(CYC_PER_US - 1);
	localparam logic [31:0] TICK_RESET_VAL = 32'h0000_0000;

	// ****************************************
	// record byte indices
	// ****************************************
	localparam logic [4:0] IDX_MOD_SUMMARY = 5'h00;
	localparam logic [4:0] IDX_MOD_CLASS = 5'h01;
	localparam logic [4:0] IDX_RSVD_C = 5'h02;
	localparam logic [4:0] IDX_MOD_FLAGS = 5'h03;
	localparam logic [4:0] IDX_TYPE = 5'h04;
	localparam logic [4:0] IDX_BITS = 5'h05;
	localparam logic [4:0] IDX_COUNT = 5'h06;
	localparam logic [4:0] IDX_SUMMARY = 5'h07;
	localparam logic [4:0] IDX_CH_FIRST = 5'h08;
	localparam logic [4:0] IDX_UNUSED_FIRST = 5'h0C;
	localparam logic [4:0] IDX_STAMP_FIRST = 5'h10;
	localparam logic [4:0] IDX_LAST = 5'h13;

	// ****************************************
	// field positions
	// ****************************************
	localparam int MOD_BUF_OVF_BIT = 3;
	localparam int MOD_COMM_BIT = 4;
	localparam int MOD_PI_LOST_BIT = 6;
	localparam int SUM_CHAN_ERR_BIT = 3;
	localparam int CH_CFG_BIT = 0;
	localparam int CH_PI_BIT = 5;
	localparam int CH_UNDER_BIT = 6;
	localparam int CH_OVER_BIT = 7;
	localparam logic [7:0] MOD_FLAGS_RSVD = 8'hA7;
	localparam logic [7:0] CH_ERR_RSVD = 8'h1E;

	// ****************************************
	// constant field values
	// ****************************************
	localparam logic [6:0] TYPE_DIGITAL_IN = 7'h70;
	localparam logic [6:0] TYPE_ANALOG_IN = 7'h71;
	localparam logic [6:0] TYPE_DIGITAL_OUT = 7'h72;
	localparam logic [6:0] TYPE_ANALOG_OUT = 7'h73;
	localparam logic [6:0] TYPE_ANALOG_IO = 7'h74;
	localparam logic [6:0] TYPE_COUNTER = 7'h76;
	localparam logic [7:0] BITS_PER_CH = 8'h08;
	localparam logic [7:0] NUM_CH = 8'h04;
	localparam logic [7:0] MOD_CLASS = 8'h15;
	localparam int NUM_USED_CH = 4;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic over;
		logic under;
		logic pi_lost;
		logic cfg_err;
	} chan_cause_t;

	typedef struct packed {
		logic pi_lost;
		logic comm_err;
		logic buf_ovf;
	} mod_cause_t;

	typedef enum logic [0:0] {
		ST_QUIET = 1'b0,
		ST_ACTIVE = 1'b1
	} diag_state_t;

	typedef struct packed {
		diag_state_t state;
		logic [7:0] mod_flags;
		logic [7:0] summary;
		logic [3:0][7:0] ch_err;
		logic [31:0] stamp;
		logic incoming;
		logic going;
		logic rd_valid;
		logic [7:0] rd_data;
	} rec_state_t;

	localparam rec_state_t REC_RESET = '{state: ST_QUIET, default: '0};

	typedef struct packed {
		logic [7:0] pre;
		logic [31:0] us;
	} ticker_state_t;

	localparam ticker_state_t TICK_RESET = '{pre: 8'h00, us: TICK_RESET_VAL};

endpackage : diag_record_pkg

//--- rtl/us_ticker.sv
// free-running 32-bit microsecond ticker
`timescale 1ns/1ps
`default_nettype none
module us_ticker (
	input wire logic clk,
	input wire logic rst,
	output logic [31:0] us_count
);

	diag_record_pkg::ticker_state_t s_q;
	diag_record_pkg::ticker_state_t s_d;

	// ****************************************
	// prescaler and counter
	// ****************************************
	always_comb
	begin
		s_d = s_q;
		if (s_q.pre == diag_record_pkg::PRE_LAST)
		begin
			s_d.pre = 8'h00;
			// natural 32-bit wrap after the top value
			s_d.us = s_q.us + 32'h0000_0001;
		end
		else
		begin
			s_d.pre = s_q.pre + 8'h01;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s_q <= diag_record_pkg::TICK_RESET;
		else
			s_q <= s_d;
	end

	assign us_count = s_q.us;

	// ****************************************
	// checks
	// ****************************************
	chk_tick_step: assert property (@(posedge clk) disable iff (rst)
		$changed(s_q.us) |-> s_q.us == $past(s_q.us) + 32'h0000_0001)
		else $error("ticker did not step by one");

	chk_tick_rate: assert property (@(posedge clk) disable iff (rst)
		(s_q.pre != diag_record_pkg::PRE_LAST) |=> $stable(s_q.us))
		else $error("ticker moved before a full microsecond");

endmodule : us_ticker
`default_nettype wire

//--- rtl/diag_record.sv
// diagnostic record of a four-channel analog input module
`timescale 1ns/1ps
`default_nettype none
module diag_record (
	input wire logic clk,
	input wire logic rst,
	input wire diag_record_pkg::chan_cause_t [3:0] chan_cause,
	input wire diag_record_pkg::mod_cause_t mod_cause,
	input wire logic rd_req,
	input wire logic [4:0] rd_index,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic diag_incoming,
	output logic diag_going,
	output logic diag_active
);

	// ****************************************
	// functions
	// ****************************************
	function automatic logic [7:0] chan_byte(input diag_record_pkg::chan_cause_t c);
		logic [7:0] b;
		b = 8'h00;
		b[diag_record_pkg::CH_CFG_BIT] = c.cfg_err;
		b[diag_record_pkg::CH_PI_BIT] = c.pi_lost;
		b[diag_record_pkg::CH_UNDER_BIT] = c.under;
		b[diag_record_pkg::CH_OVER_BIT] = c.over;
		return b;
	endfunction : chan_byte

	function automatic logic [7:0] mod_byte(input diag_record_pkg::mod_cause_t m,
		input logic chan_pi_lost);
		logic [7:0] b;
		b = 8'h00;
		b[diag_record_pkg::MOD_BUF_OVF_BIT] = m.buf_ovf;
		b[diag_record_pkg::MOD_COMM_BIT] = m.comm_err;
		b[diag_record_pkg::MOD_PI_LOST_BIT] = m.pi_lost | chan_pi_lost;
		return b;
	endfunction : mod_byte

	function automatic logic [7:0] read_byte(input diag_record_pkg::rec_state_t r,
		input logic [4:0] idx);
		logic [7:0] b;
		logic [4:0] off;
		b = 8'h00;
		off = 5'h00;
		if (idx == diag_record_pkg::IDX_MOD_SUMMARY)
			b[diag_record_pkg::SUM_CHAN_ERR_BIT] = |r.summary;
		else if (idx == diag_record_pkg::IDX_MOD_CLASS)
			b = diag_record_pkg::MOD_CLASS;
		else if (idx == diag_record_pkg::IDX_MOD_FLAGS)
			b = r.mod_flags;
		else if (idx == diag_record_pkg::IDX_TYPE)
			b = {1'b0, diag_record_pkg::TYPE_ANALOG_IN};
		else if (idx == diag_record_pkg::IDX_BITS)
			b = diag_record_pkg::BITS_PER_CH;
		else if (idx == diag_record_pkg::IDX_COUNT)
			b = diag_record_pkg::NUM_CH;
		else if (idx == diag_record_pkg::IDX_SUMMARY)
			b = r.summary;
		else if (idx >= diag_record_pkg::IDX_CH_FIRST &&
			idx < diag_record_pkg::IDX_UNUSED_FIRST)
		begin
			off = idx - diag_record_pkg::IDX_CH_FIRST;
			b = r.ch_err[off[1:0]];
		end
		else if (idx >= diag_record_pkg::IDX_STAMP_FIRST &&
			idx <= diag_record_pkg::IDX_LAST)
		begin
			off = idx - diag_record_pkg::IDX_STAMP_FIRST;
			b = r.stamp[{off[1:0], 3'b000} +: 8];
		end
		// reserved and unused channel bytes fall through as zero
		return b;
	endfunction : read_byte

	// ****************************************
	// microsecond ticker
	// ****************************************
	logic [31:0] us_count;

	us_ticker u_ticker (
		.clk(clk),
		.rst(rst),
		.us_count(us_count)
	);

	// ****************************************
	// live cause bytes
	// ****************************************
	logic [3:0][7:0] live_ch;
	logic [3:0] live_group;
	logic [3:0] chan_pi;
	logic [7:0] live_mod;
	logic live_any;

	genvar gi;
	generate
		for (gi = 0; gi < diag_record_pkg::NUM_USED_CH; gi++)
		begin : g_chan
			assign live_ch[gi] = chan_byte(chan_cause[gi]);
			assign live_group[gi] = |live_ch[gi];
			assign chan_pi[gi] = chan_cause[gi].pi_lost;
		end
	endgenerate

	assign live_mod = mod_byte(mod_cause, |chan_pi);
	assign live_any = (|live_mod) | (|live_group);

	// ****************************************
	// record state
	// ****************************************
	diag_record_pkg::rec_state_t s_q;
	diag_record_pkg::rec_state_t s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.incoming = 1'b0;
		s_d.going = 1'b0;
		s_d.rd_valid = rd_req;
		s_d.rd_data = rd_req ? read_byte(s_q, rd_index) : 8'h00;
		unique case (s_q.state)
			diag_record_pkg::ST_QUIET:
			begin
				if (live_any)
				begin
					s_d.state = diag_record_pkg::ST_ACTIVE;
					s_d.mod_flags = live_mod;
					s_d.ch_err = live_ch;
					s_d.summary = {4'h0, live_group};
					s_d.stamp = us_count;
					s_d.incoming = 1'b1;
				end
			end
			diag_record_pkg::ST_ACTIVE:
			begin
				// record stays frozen; changes while active are dropped
				if (!live_any)
				begin
					s_d.state = diag_record_pkg::ST_QUIET;
					s_d.mod_flags = 8'h00;
					s_d.ch_err = '0;
					s_d.summary = 8'h00;
					s_d.stamp = us_count;
					s_d.going = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s_q <= diag_record_pkg::REC_RESET;
		else
			s_q <= s_d;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign rd_valid = s_q.rd_valid;
	assign rd_data = s_q.rd_data;
	assign diag_incoming = s_q.incoming;
	assign diag_going = s_q.going;
	assign diag_active = s_q.state == diag_record_pkg::ST_ACTIVE;

	// ****************************************
	// checks
	// ****************************************
	sequence s_enter;
		s_q.state == diag_record_pkg::ST_QUIET && live_any;
	endsequence

	sequence s_leave;
		s_q.state == diag_record_pkg::ST_ACTIVE && !live_any;
	endsequence

	sequence s_hold;
		s_q.state == diag_record_pkg::ST_ACTIVE && live_any;
	endsequence

	sequence s_read(logic [4:0] idx);
		rd_req && rd_index == idx;
	endsequence

	chk_buf_ovf_bit: assert property (@(posedge clk) disable iff (rst)
		s_enter ##0 mod_cause.buf_ovf |=> s_q.mod_flags[3] && diag_incoming)
		else $error("buffer overflow not recorded");

	chk_comm_err_bit: assert property (@(posedge clk) disable iff (rst)
		s_enter ##0 mod_cause.comm_err |=> s_q.mod_flags[4])
		else $error("communication error not recorded");

	chk_pi_lost_bit: assert property (@(posedge clk) disable iff (rst)
		s_enter ##0 mod_cause.pi_lost |=> s_q.mod_flags[6])
		else $error("lost process interrupt not recorded");

	chk_mod_reserved: assert property (@(posedge clk) disable iff (rst)
		(s_q.mod_flags & diag_record_pkg::MOD_FLAGS_RSVD) == 8'h00)
		else $error("reserved module flag set");

	chk_type_read: assert property (@(posedge clk) disable iff (rst)
		s_read(diag_record_pkg::IDX_TYPE) |=> rd_valid && rd_data == 8'h71)
		else $error("wrong channel type code");

	chk_bits_read: assert property (@(posedge clk) disable iff (rst)
		s_read(diag_record_pkg::IDX_BITS) |=> rd_valid && rd_data == 8'h08)
		else $error("wrong bits per channel");

	chk_count_read: assert property (@(posedge clk) disable iff (rst)
		s_read(diag_record_pkg::IDX_COUNT) |=> rd_valid && rd_data == 8'h04)
		else $error("wrong channel count");

	chk_summary_or: assert property (@(posedge clk) disable iff (rst)
		s_q.summary == {4'h0, s_q.ch_err[3] != 8'h00, s_q.ch_err[2] != 8'h00,
			s_q.ch_err[1] != 8'h00, s_q.ch_err[0] != 8'h00})
		else $error("group summary does not match channel bytes");

	chk_summary_set: assert property (@(posedge clk) disable iff (rst)
		s_enter ##0 chan_cause[2].over |=> s_q.summary[2] && s_q.ch_err[2][7])
		else $error("group summary bit missing");

	chk_chan_cfg: assert property (@(posedge clk) disable iff (rst)
		s_enter |=> s_q.ch_err[0][0] == $past(chan_cause[0].cfg_err))
		else $error("configuration error bit wrong");

	chk_chan_pi: assert property (@(posedge clk) disable iff (rst)
		s_enter |=> s_q.ch_err[1][5] == $past(chan_cause[1].pi_lost))
		else $error("channel lost interrupt bit wrong");

	chk_chan_under: assert property (@(posedge clk) disable iff (rst)
		s_enter |=> s_q.ch_err[3][6] == $past(chan_cause[3].under))
		else $error("underflow bit wrong");

	chk_chan_over: assert property (@(posedge clk) disable iff (rst)
		s_enter |=> s_q.ch_err[0][7] == $past(chan_cause[0].over))
		else $error("overflow bit wrong");

	chk_stamp_capture: assert property (@(posedge clk) disable iff (rst)
		(s_enter or s_leave) |=> s_q.stamp == $past(us_count))
		else $error("timestamp not captured");

	chk_chan_flag: assert property (@(posedge clk) disable iff (rst)
		s_read(diag_record_pkg::IDX_MOD_SUMMARY) ##0 (s_q.summary != 8'h00)
		|=> rd_data == 8'h08)
		else $error("channel error summary bit missing");

	chk_going_event: assert property (@(posedge clk) disable iff (rst)
		s_leave |=> diag_going && !diag_active ##1 !diag_going)
		else $error("outgoing event missing");

	chk_hold_frozen: assert property (@(posedge clk) disable iff (rst)
		s_hold |=> $stable(s_q.ch_err) && $stable(s_q.stamp) && !diag_incoming)
		else $error("record changed while diagnostic active");

	chk_unused_zero: assert property (@(posedge clk) disable iff (rst)
		rd_req && rd_index >= diag_record_pkg::IDX_UNUSED_FIRST &&
		rd_index < diag_record_pkg::IDX_STAMP_FIRST |=> rd_data == 8'h00)
		else $error("unused channel byte not zero");

	chk_chan_reserved: assert property (@(posedge clk) disable iff (rst)
		(s_q.ch_err[0] & diag_record_pkg::CH_ERR_RSVD) == 8'h00 &&
		(s_q.ch_err[3] & diag_record_pkg::CH_ERR_RSVD) == 8'h00)
		else $error("reserved channel bit set");

	sequence s_captured;
		diag_incoming && diag_active;
	endsequence

	chk_incoming_event: assert property (@(posedge clk) disable iff (rst)
		s_enter |=> s_captured ##1 !diag_incoming)
		else $error("incoming event missing");

	chk_quiet_empty: assert property (@(posedge clk) disable iff (rst)
		!diag_active |-> s_q.mod_flags == 8'h00 && s_q.summary == 8'h00 && s_q.ch_err == '0)
		else $error("record not empty outside the window");

	chk_flags_read: assert property (@(posedge clk) disable iff (rst)
		s_read(diag_record_pkg::IDX_MOD_FLAGS)
		|=> rd_valid && rd_data == $past(s_q.mod_flags))
		else $error("module flags read wrong");

	chk_group_read: assert property (@(posedge clk) disable iff (rst)
		s_read(diag_record_pkg::IDX_SUMMARY)
		|=> rd_valid && rd_data == $past(s_q.summary))
		else $error("group summary read wrong");

	chk_summary_rsvd: assert property (@(posedge clk) disable iff (rst)
		s_q.summary[7:4] == 4'h0)
		else $error("reserved summary bit set");

	chk_chan0_read: assert property (@(posedge clk) disable iff (rst)
		s_read(diag_record_pkg::IDX_CH_FIRST)
		|=> rd_valid && rd_data == $past(s_q.ch_err[0]))
		else $error("channel byte read wrong");

	chk_pi_to_module: assert property (@(posedge clk) disable iff (rst)
		s_enter ##0 chan_cause[3].pi_lost |=> s_q.ch_err[3][5] && s_q.mod_flags[6])
		else $error("channel lost interrupt not recorded");

	chk_stamp_low: assert property (@(posedge clk) disable iff (rst)
		s_read(diag_record_pkg::IDX_STAMP_FIRST)
		|=> rd_valid && rd_data == $past(s_q.stamp[7:0]))
		else $error("timestamp low byte read wrong");

	chk_stamp_high: assert property (@(posedge clk) disable iff (rst)
		s_read(diag_record_pkg::IDX_LAST)
		|=> rd_valid && rd_data == $past(s_q.stamp[31:24]))
		else $error("timestamp high byte read wrong");

	chk_idle_zero: assert property (@(posedge clk) disable iff (rst)
		!rd_req |=> !rd_valid && rd_data == 8'h00)
		else $error("read answer without request");

	chk_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
		rd_req && rd_index > diag_record_pkg::IDX_LAST |=> rd_valid && rd_data == 8'h00)
		else $error("unmapped byte not zero");

	chk_rsvd_byte: assert property (@(posedge clk) disable iff (rst)
		s_read(diag_record_pkg::IDX_RSVD_C)
		|=> rd_valid && rd_data == 8'h00)
		else $error("reserved byte not zero");

	chk_flag_clear: assert property (@(posedge clk) disable iff (rst)
		s_read(diag_record_pkg::IDX_MOD_SUMMARY) ##0 (s_q.summary == 8'h00)
		|=> rd_valid && rd_data == 8'h00)
		else $error("channel error summary bit without error");

endmodule : diag_record
`default_nettype wire

//--- bench/coupler_model.sv
// bus coupler model that fetches bytes of the diagnostic record
`timescale 1ns/1ps
`default_nettype none
module coupler_model (
	input wire logic clk,
	output logic rd_req,
	output logic [4:0] rd_index,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data
);
	initial
	begin
		rd_req = 1'b0;
		rd_index = 5'h00;
	end

	// ****************************************
	// one read, optionally after idle cycles
	// ****************************************
	task automatic fetch(input logic [4:0] idx, input int slow,
		output logic [7:0] data, output logic ok);
		int i;
		ok = 1'b0;
		data = 8'h00;
		repeat (slow) @(negedge clk);
		@(negedge clk);
		rd_req = 1'b1;
		rd_index = idx;
		for (i = 0; i < 4; i++)
		begin
			@(negedge clk);
			rd_req = 1'b0;
			// index no longer qualified: show a changed value
			rd_index = ~idx;
			if (rd_valid === 1'b1)
			begin
				data = rd_data;
				ok = 1'b1;
				break;
			end
		end
	endtask : fetch
endmodule : coupler_model
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the diagnostic record
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, what) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) \
		begin \
			err_total++; \
			$display("CHECK FAILED at %0t: %s", $time, what); \
		end \
	end
module testbench;
	logic clk;
	logic rst;
	diag_record_pkg::chan_cause_t [3:0] chan_cause;
	diag_record_pkg::mod_cause_t mod_cause;
	logic rd_req;
	logic [4:0] rd_index;
	logic rd_valid;
	logic [7:0] rd_data;
	logic diag_incoming;
	logic diag_going;
	logic diag_active;
	int err_total;
	int n_checks;
	int cyc;
	logic [7:0] got;
	logic ok;
	logic [31:0] stamp_exp;
	logic [7:0] chmap [4] = '{8'h01, 8'h20, 8'h40, 8'h80};
	logic [7:0] modmap [3] = '{8'h08, 8'h10, 8'h40};

	always #2 clk = ~clk;
	always @(posedge clk) cyc <= rst ? 0 : cyc + 1;

	diag_record dut (.clk(clk), .rst(rst), .chan_cause(chan_cause), .mod_cause(mod_cause),
		.rd_req(rd_req), .rd_index(rd_index), .rd_valid(rd_valid), .rd_data(rd_data),
		.diag_incoming(diag_incoming), .diag_going(diag_going), .diag_active(diag_active));

	coupler_model coupler (.clk(clk), .rd_req(rd_req), .rd_index(rd_index),
		.rd_valid(rd_valid), .rd_data(rd_data));

	// ****************************************
	// tasks
	// ****************************************
	task automatic wrap_up;
		if (err_total == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	task automatic rd(input logic [4:0] idx, input logic [7:0] exp, input int slow);
		coupler.fetch(idx, slow, got, ok);
		`CHK(ok, 1'b1, "no read answer")
		`CHK(got, exp, "read byte mismatch")
		if (ok !== 1'b1)
			wrap_up();
	endtask : rd

	// which: 0 waits for incoming, 1 for going
	task automatic wait_pulse(input logic which);
		int i;
		logic seen;
		seen = 1'b0;
		for (i = 0; i < 20 && !seen; i++)
		begin
			@(posedge clk);
			#1;
			seen = ((which ? diag_going : diag_incoming) === 1'b1);
		end
		`CHK(seen, 1'b1, "diagnostic pulse missing")
		if (!seen)
			wrap_up();
	endtask : wait_pulse

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		chan_cause = '0;
		mod_cause = '0;
		err_total = 0;
		n_checks = 0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		rd(5'h04, 8'h71, 0);
		rd(5'h05, 8'h08, 2);
		rd(5'h06, 8'h04, 0);
		rd(5'h03, 8'h00, 1);
		rd(5'h07, 8'h00, 0);
		for (int i = 0; i < 4; i++)
			rd(5'(12 + i), 8'h00, 0);
		rd(5'h14, 8'h00, 0);
		rd(5'h02, 8'h00, 0);
		rd(5'h00, 8'h00, 0);
		rd(5'h01, diag_record_pkg::MOD_CLASS, 0);
		`CHK(diag_active, 1'b0, "window open after reset")
		for (int ch = 0; ch < 4; ch++)
			for (int b = 0; b < 4; b++)
			begin
				// raise mid-microsecond so the stamp cannot straddle a tick
				for (int k = 0; k < 300 && cyc % diag_record_pkg::CYC_PER_US != 100; k++)
					@(negedge clk);
				`CHK(cyc % diag_record_pkg::CYC_PER_US, 100, "tick phase not reached")
				stamp_exp = 32'(cyc / diag_record_pkg::CYC_PER_US);
				chan_cause[ch] = diag_record_pkg::chan_cause_t'(4'(1 << b));
				wait_pulse(1'b0);
				rd(5'(8 + ch), chmap[b], 0);
				rd(5'h07, 8'(1 << ch), 1);
				rd(5'h00, 8'h08, 0);
				rd(5'h03, (b == 1) ? 8'h40 : 8'h00, 0);
				for (int j = 0; j < 4; j++)
					rd(5'(16 + j), 8'(stamp_exp >> (8 * j)), 0);
				@(negedge clk);
				chan_cause[(ch + 1) % 4] = diag_record_pkg::chan_cause_t'(4'h8);
				rd(5'(8 + (ch + 1) % 4), 8'h00, 0);
				`CHK(diag_active, 1'b1, "window closed early")
				@(negedge clk);
				chan_cause = '0;
				wait_pulse(1'b1);
				`CHK(diag_active, 1'b0, "window still open")
				rd(5'(8 + ch), 8'h00, 0);
			end
		for (int b = 0; b < 3; b++)
		begin
			@(negedge clk);
			mod_cause = diag_record_pkg::mod_cause_t'(3'(1 << b));
			wait_pulse(1'b0);
			rd(5'h03, modmap[b], 0);
			rd(5'h07, 8'h00, 0);
			@(negedge clk);
			mod_cause = '0;
			wait_pulse(1'b1);
		end
		// mid-run reset drops the record and restarts the ticker
		@(negedge clk);
		chan_cause[1] = diag_record_pkg::chan_cause_t'(4'h4);
		wait_pulse(1'b0);
		@(negedge clk);
		rst = 1'b1;
		chan_cause = '0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		`CHK(diag_active, 1'b0, "window open after mid-run reset")
		rd(5'h09, 8'h00, 0);
		for (int k = 0; k < 300 && cyc != 100; k++)
			@(negedge clk);
		`CHK(cyc, 100, "tick phase not reached after reset")
		chan_cause[2] = diag_record_pkg::chan_cause_t'(4'h1);
		wait_pulse(1'b0);
		rd(5'h10, 8'h00, 0);
		rd(5'h11, 8'h00, 0);
		rd(5'h0A, 8'h01, 0);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
